// *** usb_term_pkg.sv ***
package usb_term_pkg;

   // speed select codes
   localparam logic [1:0] SPD_HS = 2'h0;
   localparam logic [1:0] SPD_FS = 2'h1;
   localparam logic [1:0] SPD_LS = 2'h2;

   // operating mode codes
   localparam logic [1:0] OPM_NORMAL   = 2'h0;
   localparam logic [1:0] OPM_TRISTATE = 2'h1;
   localparam logic [1:0] OPM_RAW      = 2'h2;

   // register fields written by the link
   typedef struct packed {
      logic [1:0] speed_select;
      logic       termination_select;
      logic [1:0] op_mode;
      logic       dplus_pulldown_bit;
      logic       dminus_pulldown_bit;
   } fields_t;

   // power-up and low-vbus defaults
   localparam fields_t DEFAULT_FIELDS = '{
      speed_select:        SPD_FS,
      termination_select:  1'b0,
      op_mode:             OPM_NORMAL,
      dplus_pulldown_bit:  1'b1,
      dminus_pulldown_bit: 1'b1
   };

   // resistor enables towards the analog front end
   typedef struct packed {
      logic dplus_pullup_enable;
      logic dminus_pullup_enable;
      logic dplus_pulldown_enable;
      logic dminus_pulldown_enable;
      logic hs_termination_enable;
   } resistors_t;

   localparam resistors_t RES_ALL_OFF        = '0;
   localparam resistors_t RES_PULLDOWNS_ONLY = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

   // line levels, serial framing constants
   localparam logic       LEVEL_J      = 1'b1;
   localparam logic       LEVEL_K      = 1'b0;
   localparam logic [7:0] SYNC_BYTE    = 8'h80;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [2:0] STUFF_LIMIT  = 3'h6;
   localparam logic [1:0] EOP_SE0_BITS = 2'h2;

   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_SYNC = 2'h1,
      TX_DATA = 2'h3,
      TX_EOP  = 2'h2
   } txstate_t;

   // whole state of the line block
   typedef struct packed {
      resistors_t res;
      txstate_t   state;
      logic [7:0] shift;
      logic [2:0] bitCnt;
      logic [2:0] onesCnt;
      logic [1:0] eopCnt;
      logic       level;
      logic       raw;
      logic       txReady;
      logic       lineOeN;
      logic       lineDp;
      logic       lineDm;
   } core_t;

   localparam core_t CORE_RESET = '{
      res:     RES_PULLDOWNS_ONLY,
      state:   TX_IDLE,
      shift:   8'h00,
      bitCnt:  3'h0,
      onesCnt: 3'h0,
      eopCnt:  2'h0,
      level:   LEVEL_J,
      raw:     1'b0,
      txReady: 1'b0,
      lineOeN: 1'b1,
      lineDp:  1'b1,
      lineDm:  1'b0
   };

endpackage

// *** usb_resistor_decode.sv ***
`timescale 1ns/1ns
module usb_resistor_decode (
   input  usb_term_pkg::fields_t    fields,
   output usb_term_pkg::resistors_t enables
);

   logic tristate;
   logic pullupWanted;

   // per-field decode of the five resistor enables
   always_comb begin
      tristate     = fields.op_mode == usb_term_pkg::OPM_TRISTATE;
      pullupWanted = fields.termination_select && !fields.dplus_pulldown_bit;
      enables      = usb_term_pkg::RES_ALL_OFF;
      if (!tristate) begin
         enables.dplus_pulldown_enable  = fields.dplus_pulldown_bit;
         enables.dminus_pulldown_enable = fields.dminus_pulldown_bit;
         enables.dminus_pullup_enable   = pullupWanted &&
            fields.speed_select == usb_term_pkg::SPD_LS;
         enables.dplus_pullup_enable    = pullupWanted &&
            fields.speed_select != usb_term_pkg::SPD_LS;
         enables.hs_termination_enable  = !fields.termination_select &&
            fields.speed_select == usb_term_pkg::SPD_HS;
      end
   end

endmodule

// *** usb_line_termination_decoder.sv ***
`timescale 1ns/1ns
module usb_line_termination_decoder (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire usb_term_pkg::fields_t    xcvrFields,
   input  wire logic                     vbusBelowSessEnd,
   input  wire logic                     txValid,
   input  wire logic [7:0]               txData,
   output usb_term_pkg::resistors_t      resistorEnables,
   output logic                          txReady,
   output logic                          lineOeN,
   output logic                          lineDp,
   output logic                          lineDm
);

   usb_term_pkg::core_t      cur_ff;
   usb_term_pkg::core_t      nxt_cur;
   usb_term_pkg::fields_t    eff;
   usb_term_pkg::resistors_t decoded;
   logic                     tristate;
   logic                     lowSpeed;
   logic                     resume;
   logic                     drive;
   logic                     se0;

   // defaults replace the link fields while vbus is low
   assign eff = vbusBelowSessEnd ? usb_term_pkg::DEFAULT_FIELDS : xcvrFields;

   usb_resistor_decode u_decode (
      .fields  (eff),
      .enables (decoded)
   );

   // next state: resistor enables and serial framing
   always_comb begin
      tristate = eff.op_mode == usb_term_pkg::OPM_TRISTATE;
      lowSpeed = eff.speed_select == usb_term_pkg::SPD_LS;
      resume   = eff.op_mode == usb_term_pkg::OPM_RAW &&
                 eff.speed_select != usb_term_pkg::SPD_HS;
      drive    = 1'b0;
      se0      = 1'b0;
      nxt_cur  = cur_ff;
      nxt_cur.res     = decoded;
      nxt_cur.txReady = 1'b0;
      case (cur_ff.state)
         usb_term_pkg::TX_IDLE: begin
            if (resume) begin
               drive         = 1'b1;
               nxt_cur.level = usb_term_pkg::LEVEL_K;
            end else if (!tristate && txValid) begin
               nxt_cur.raw     = eff.op_mode == usb_term_pkg::OPM_RAW;
               nxt_cur.bitCnt  = 3'h0;
               nxt_cur.onesCnt = 3'h0;
               nxt_cur.level   = usb_term_pkg::LEVEL_J;
               if (eff.op_mode == usb_term_pkg::OPM_RAW) begin
                  nxt_cur.state   = usb_term_pkg::TX_DATA;
                  nxt_cur.shift   = txData;
                  nxt_cur.txReady = 1'b1;
               end else begin
                  nxt_cur.state = usb_term_pkg::TX_SYNC;
                  nxt_cur.shift = usb_term_pkg::SYNC_BYTE;
               end
            end else begin
               nxt_cur.level = usb_term_pkg::LEVEL_J;
            end
         end
         usb_term_pkg::TX_SYNC, usb_term_pkg::TX_DATA: begin
            drive = 1'b1;
            if (!cur_ff.raw && cur_ff.onesCnt == usb_term_pkg::STUFF_LIMIT) begin
               // stuffed zero, data bit waits
               nxt_cur.level   = ~cur_ff.level;
               nxt_cur.onesCnt = 3'h0;
            end else begin
               if (cur_ff.raw) begin
                  nxt_cur.level = cur_ff.shift[0];
               end else if (!cur_ff.shift[0]) begin
                  nxt_cur.level = ~cur_ff.level; // nrzi: zero toggles
               end
               nxt_cur.onesCnt = cur_ff.shift[0] ? cur_ff.onesCnt + 3'h1 : 3'h0;
               nxt_cur.shift   = {1'b0, cur_ff.shift[7:1]};
               nxt_cur.bitCnt  = cur_ff.bitCnt + 3'h1;
               if (cur_ff.bitCnt == usb_term_pkg::BIT_LAST) begin
                  if (txValid) begin
                     nxt_cur.state   = usb_term_pkg::TX_DATA;
                     nxt_cur.shift   = txData;
                     nxt_cur.txReady = 1'b1;
                  end else if (cur_ff.raw) begin
                     nxt_cur.state = usb_term_pkg::TX_IDLE;
                  end else begin
                     nxt_cur.state  = usb_term_pkg::TX_EOP;
                     nxt_cur.eopCnt = 2'h0;
                  end
               end
            end
         end
         usb_term_pkg::TX_EOP: begin
            drive = 1'b1;
            if (cur_ff.onesCnt == usb_term_pkg::STUFF_LIMIT) begin
               nxt_cur.level   = ~cur_ff.level;
               nxt_cur.onesCnt = 3'h0;
            end else if (cur_ff.eopCnt < usb_term_pkg::EOP_SE0_BITS) begin
               se0            = 1'b1;
               nxt_cur.eopCnt = cur_ff.eopCnt + 2'h1;
            end else begin
               nxt_cur.level   = usb_term_pkg::LEVEL_J;
               nxt_cur.onesCnt = 3'h0;
               nxt_cur.state   = usb_term_pkg::TX_IDLE;
            end
         end
         default: begin
            nxt_cur.state = usb_term_pkg::TX_IDLE;
         end
      endcase
      // tristate drops the drivers and aborts any packet
      if (tristate) begin
         drive           = 1'b0;
         nxt_cur.state   = usb_term_pkg::TX_IDLE;
         nxt_cur.txReady = 1'b0;
      end
      nxt_cur.lineOeN = ~drive;
      nxt_cur.lineDp  = !se0 && (nxt_cur.level ^ lowSpeed);
      nxt_cur.lineDm  = !se0 && !(nxt_cur.level ^ lowSpeed);
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= usb_term_pkg::CORE_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // outputs straight from the state register
   assign resistorEnables = cur_ff.res;
   assign txReady         = cur_ff.txReady;
   assign lineOeN         = cur_ff.lineOeN;
   assign lineDp          = cur_ff.lineDp;
   assign lineDm          = cur_ff.lineDm;

   // checks on resistor decode and framing
   AST_TRISTATE_ALL_OFF: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode == usb_term_pkg::OPM_TRISTATE)
      |=> resistorEnables == usb_term_pkg::RES_ALL_OFF && lineOeN)
      else $error("tristate mode left a resistor or driver on");

   AST_DEFAULT_PULLDOWNS: assert property (@(posedge clk) disable iff (!nrst)
      vbusBelowSessEnd |=> resistorEnables == usb_term_pkg::RES_PULLDOWNS_ONLY)
      else $error("low vbus did not give pull-downs only");

   AST_PULLDOWN_FOLLOW: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode != usb_term_pkg::OPM_TRISTATE)
      |=> resistorEnables.dplus_pulldown_enable == $past(xcvrFields.dplus_pulldown_bit) &&
          resistorEnables.dminus_pulldown_enable == $past(xcvrFields.dminus_pulldown_bit))
      else $error("pull-down enables do not follow their bits");

   AST_HS_TERMINATION: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode != usb_term_pkg::OPM_TRISTATE &&
       xcvrFields.speed_select == usb_term_pkg::SPD_HS && !xcvrFields.termination_select)
      |=> resistorEnables.hs_termination_enable && !resistorEnables.dplus_pullup_enable &&
          !resistorEnables.dminus_pullup_enable)
      else $error("high-speed termination decode wrong");

   AST_FS_PERIPHERAL: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode != usb_term_pkg::OPM_TRISTATE &&
       xcvrFields.speed_select == usb_term_pkg::SPD_FS && xcvrFields.termination_select &&
       !xcvrFields.dplus_pulldown_bit)
      |=> resistorEnables.dplus_pullup_enable && !resistorEnables.dminus_pullup_enable &&
          !resistorEnables.hs_termination_enable)
      else $error("full-speed peripheral pull-up wrong");

   AST_LS_PERIPHERAL: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode != usb_term_pkg::OPM_TRISTATE &&
       xcvrFields.speed_select == usb_term_pkg::SPD_LS && xcvrFields.termination_select &&
       !xcvrFields.dplus_pulldown_bit)
      |=> resistorEnables.dminus_pullup_enable && !resistorEnables.dplus_pullup_enable &&
          !resistorEnables.hs_termination_enable)
      else $error("low-speed peripheral pull-up wrong");

   AST_PERIPH_CHIRP: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode == usb_term_pkg::OPM_RAW &&
       xcvrFields.speed_select == usb_term_pkg::SPD_HS && xcvrFields.termination_select &&
       !xcvrFields.dplus_pulldown_bit)
      |=> resistorEnables.dplus_pullup_enable && !resistorEnables.hs_termination_enable)
      else $error("peripheral chirp resistors wrong");

   AST_HOST_FSLS: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode != usb_term_pkg::OPM_TRISTATE &&
       xcvrFields.speed_select != usb_term_pkg::SPD_HS && xcvrFields.termination_select &&
       xcvrFields.dplus_pulldown_bit && xcvrFields.dminus_pulldown_bit)
      |=> resistorEnables == usb_term_pkg::RES_PULLDOWNS_ONLY)
      else $error("host full or low speed resistors wrong");

   AST_RESUME_K: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode == usb_term_pkg::OPM_RAW &&
       xcvrFields.speed_select == usb_term_pkg::SPD_FS && cur_ff.state == usb_term_pkg::TX_IDLE)
      |=> !lineOeN && !lineDp && lineDm)
      else $error("resume does not drive full-speed K");

   AST_SYNC_LENGTH: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state == usb_term_pkg::TX_IDLE && txValid && !vbusBelowSessEnd &&
       xcvrFields.op_mode == usb_term_pkg::OPM_NORMAL)
      |=> (cur_ff.state == usb_term_pkg::TX_SYNC) [*8] ##1 cur_ff.state != usb_term_pkg::TX_SYNC)
      else $error("sync field not eight bit times");

   AST_EOP_SE0: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state == usb_term_pkg::TX_EOP && cur_ff.eopCnt == 2'h0 &&
       cur_ff.onesCnt != usb_term_pkg::STUFF_LIMIT && eff.op_mode != usb_term_pkg::OPM_TRISTATE)
      |=> (!lineOeN && !lineDp && !lineDm) [*2] ##1 (!lineOeN && lineDp != lineDm))
      else $error("end of packet not two se0 then j");

   // resistor decode invariants, whatever the fields
   AST_PULLUPS_EXCLUSIVE: assert property (@(posedge clk) disable iff (!nrst)
      !(resistorEnables.dplus_pullup_enable && resistorEnables.dminus_pullup_enable))
      else $error("both pull-ups enabled together");

   AST_TERM_NO_PULLUP: assert property (@(posedge clk) disable iff (!nrst)
      resistorEnables.hs_termination_enable |->
      !resistorEnables.dplus_pullup_enable && !resistorEnables.dminus_pullup_enable)
      else $error("termination enabled beside a pull-up");

   AST_TERM_SOURCE: assert property (@(posedge clk) disable iff (!nrst)
      resistorEnables.hs_termination_enable |->
      $past(eff.speed_select) == usb_term_pkg::SPD_HS && !$past(eff.termination_select))
      else $error("termination enabled without high-speed fields");

   AST_PULLUP_SOURCE: assert property (@(posedge clk) disable iff (!nrst)
      (resistorEnables.dplus_pullup_enable || resistorEnables.dminus_pullup_enable) |->
      $past(eff.termination_select) && !$past(eff.dplus_pulldown_bit) &&
      $past(eff.op_mode) != usb_term_pkg::OPM_TRISTATE)
      else $error("pull-up enabled without termination select");

   AST_LS_PULLUP_SIDE: assert property (@(posedge clk) disable iff (!nrst)
      resistorEnables.dminus_pullup_enable |-> $past(eff.speed_select) == usb_term_pkg::SPD_LS)
      else $error("D- pull-up outside low speed");

   AST_DP_PULLUP_SIDE: assert property (@(posedge clk) disable iff (!nrst)
      resistorEnables.dplus_pullup_enable |-> $past(eff.speed_select) != usb_term_pkg::SPD_LS)
      else $error("D+ pull-up at low speed");

   // transmit framing invariants
   AST_READY_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
      txReady |=> !txReady)
      else $error("byte handshake longer than one cycle");

   AST_TRISTATE_ABORT: assert property (@(posedge clk) disable iff (!nrst)
      tristate |=> cur_ff.state == usb_term_pkg::TX_IDLE && !txReady && lineOeN)
      else $error("tristate did not abort the packet");

   AST_IDLE_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state == usb_term_pkg::TX_IDLE && !resume) |=> lineOeN)
      else $error("lines driven while idle");

   AST_FRAME_DRIVEN: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state != usb_term_pkg::TX_IDLE && !tristate) |=> !lineOeN)
      else $error("lines released inside a packet");

   AST_RAW_NO_SYNC: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state == usb_term_pkg::TX_IDLE && txValid && !tristate && !resume &&
       eff.op_mode == usb_term_pkg::OPM_RAW)
      |=> cur_ff.state == usb_term_pkg::TX_DATA && txReady)
      else $error("raw byte not taken at once");

   AST_STUFF_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
      (cur_ff.state != usb_term_pkg::TX_IDLE && !cur_ff.raw &&
       cur_ff.onesCnt == usb_term_pkg::STUFF_LIMIT)
      |=> cur_ff.level != $past(cur_ff.level))
      else $error("no stuffed zero after six ones");

   AST_SE0_IN_EOP: assert property (@(posedge clk) disable iff (!nrst)
      (!lineDp && !lineDm) |-> $past(cur_ff.state) == usb_term_pkg::TX_EOP)
      else $error("se0 outside end of packet");

   AST_LS_RESUME_K: assert property (@(posedge clk) disable iff (!nrst)
      (!vbusBelowSessEnd && xcvrFields.op_mode == usb_term_pkg::OPM_RAW &&
       xcvrFields.speed_select == usb_term_pkg::SPD_LS && cur_ff.state == usb_term_pkg::TX_IDLE)
      |=> !lineOeN && lineDp && !lineDm)
      else $error("resume does not drive low-speed K");

   COV_PERIPH_FS: cover property (@(posedge clk) disable iff (!nrst)
      resistorEnables.dplus_pullup_enable && !resistorEnables.dplus_pulldown_enable);
   COV_HS_TERM: cover property (@(posedge clk) disable iff (!nrst)
      resistorEnables.hs_termination_enable);
   COV_PACKET: cover property (@(posedge clk) disable iff (!nrst)
      cur_ff.state == usb_term_pkg::TX_DATA ##1 cur_ff.state == usb_term_pkg::TX_EOP);
   COV_RESUME: cover property (@(posedge clk) disable iff (!nrst)
      resume && !lineOeN);
   COV_STUFF: cover property (@(posedge clk) disable iff (!nrst)
      cur_ff.state == usb_term_pkg::TX_EOP && cur_ff.onesCnt == usb_term_pkg::STUFF_LIMIT);

endmodule

// *** usb_link_model.sv ***
`timescale 1ns/1ns
// link side: holds the transceiver fields it last wrote
module usb_link_model (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  wrEn,
   input  wire usb_term_pkg::fields_t wrFields,
   output usb_term_pkg::fields_t      xcvrFields
);
   usb_term_pkg::fields_t fields_ff;

   assign xcvrFields = fields_ff;

   // a write lands on the edge that sees the strobe and stands until the next one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fields_ff <= usb_term_pkg::DEFAULT_FIELDS;
      end else if (wrEn) begin
         fields_ff <= wrFields;
      end
   end
endmodule

// *** usb_line_termination_decoder_tb.sv ***
`timescale 1ns/1ns
module usb_line_termination_decoder_tb;
   logic                     clk              = 1'b0;
   logic                     nrst             = 1'b0;
   logic                     wrEn             = 1'b0;
   usb_term_pkg::fields_t    wrFields         = usb_term_pkg::DEFAULT_FIELDS;
   logic                     vbusBelowSessEnd = 1'b0;
   logic                     txValid          = 1'b0;
   logic [7:0]               txData           = 8'h00;
   usb_term_pkg::fields_t    xcvrFields;
   usb_term_pkg::resistors_t resistorEnables;
   logic                     txReady;
   logic                     lineOeN;
   logic                     lineDp;
   logic                     lineDm;
   int                       miscompares      = 0;
   int                       comparisons      = 0;
   int                       cycles           = 0;
   logic [7:0]               syncSeen;
   logic                     oeSeen;
   logic                     rdySeen;
   logic                     se0Seen;
   logic [7:0]               bitsSeen;
   // rows: fields (speed, term, opmode, dp bit, dm bit) beside the expected enables
   logic [11:0]              rows [20] = '{
      {7'h07, 5'h00}, {7'h3C, 5'h10}, {7'h23, 5'h06}, {7'h0B, 5'h07}, {7'h03, 5'h07},
      {7'h73, 5'h06}, {7'h3B, 5'h06}, {7'h53, 5'h06}, {7'h5B, 5'h06}, {7'h18, 5'h10},
      {7'h00, 5'h01}, {7'h30, 5'h10}, {7'h38, 5'h10}, {7'h50, 5'h08}, {7'h58, 5'h08},
      {7'h08, 5'h01}, {7'h19, 5'h12}, {7'h01, 5'h03}, {7'h70, 5'h10}, {7'h42, 5'h04}
   };

   always #50 clk = ~clk;

   usb_link_model link (
      .clk        (clk),
      .nrst       (nrst),
      .wrEn       (wrEn),
      .wrFields   (wrFields),
      .xcvrFields (xcvrFields)
   );

   usb_line_termination_decoder dut (
      .clk              (clk),
      .nrst             (nrst),
      .xcvrFields       (xcvrFields),
      .vbusBelowSessEnd (vbusBelowSessEnd),
      .txValid          (txValid),
      .txData           (txData),
      .resistorEnables  (resistorEnables),
      .txReady          (txReady),
      .lineOeN          (lineOeN),
      .lineDp           (lineDp),
      .lineDm           (lineDm)
   );

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
      comparisons++;
      if (seen !== expected) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // link write, then one edge for the decoder to take the new fields
   task automatic prog(input usb_term_pkg::fields_t f);
      @(posedge clk);
      wrEn <= 1'b1;
      wrFields <= f;
      @(posedge clk);
      wrEn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      check("reset enables", {3'h0, resistorEnables}, 8'h06);
      check("reset oe", {7'h00, lineOeN}, 8'h01);
      nrst <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         prog(rows[i][11:5]);
         check("enables", {3'h0, resistorEnables}, {3'h0, rows[i][4:0]});
      end
      // low vbus overrides a peripheral setting
      prog(7'h30);
      @(posedge clk);
      vbusBelowSessEnd <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check("vbus enables", {3'h0, resistorEnables}, 8'h06);
      @(posedge clk);
      vbusBelowSessEnd <= 1'b0;
      // full-speed resume drives K on the lines, pull-up stays
      prog(7'h38);
      @(negedge clk);
      check("resume lines", {5'h00, lineOeN, lineDp, lineDm}, 8'h01);
      check("resume enables", {3'h0, resistorEnables}, 8'h10);
      // one byte at full speed: sync, byte handshake, eop
      prog(7'h30);
      repeat (3) @(posedge clk);
      txValid <= 1'b1;
      txData <= 8'hFC;
      // request edge, then sync shows on the lines from the edge after it
      @(posedge clk);
      @(posedge clk);
      oeSeen = 1'b0;
      rdySeen = 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(negedge clk);
         syncSeen[k] = lineDp;
         oeSeen = oeSeen | lineOeN;
         rdySeen = rdySeen | (txReady && k < 7);
      end
      check("sync dp", syncSeen, 8'h2A);
      check("sync oe", {7'h00, oeSeen}, 8'h00);
      check("early ready", {7'h00, rdySeen}, 8'h00);
      // handshake stands beside the last sync bit
      check("ready", {7'h00, txReady}, 8'h01);
      @(posedge clk);
      txValid <= 1'b0;
      // nrzi data; six ones at the end force a stuffed bit before eop
      for (int k = 0; k < 8; k++) begin
         @(negedge clk);
         bitsSeen[k] = lineDp;
      end
      check("data dp", bitsSeen, 8'h01);
      @(negedge clk);
      check("stuff bit", {7'h00, lineDp}, 8'h01);
      se0Seen = 1'b0;
      for (int k = 0; k < 40 && lineOeN !== 1'b1; k++) begin
         @(negedge clk);
         se0Seen = se0Seen | (!lineDp && !lineDm && !lineOeN);
      end
      check("eop se0", {7'h00, se0Seen}, 8'h01);
      check("released", {7'h00, lineOeN}, 8'h01);
      // raw mode at high speed: no sync, no stuffing, bit 1 is J
      prog(7'h08);
      @(posedge clk);
      txValid <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check("raw ready", {7'h00, txReady}, 8'h01);
      @(posedge clk);
      txValid <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(negedge clk);
         bitsSeen[k] = lineDp;
      end
      check("raw dp", bitsSeen, 8'hFC);
      @(negedge clk);
      check("raw end", {7'h00, lineOeN}, 8'h01);
      // reset in mid-run goes back to pull-downs only
      @(posedge clk);
      nrst <= 1'b0;
      @(negedge clk);
      check("rerst enables", {3'h0, resistorEnables}, 8'h06);
      @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(negedge clk);
      check("rerst default", {3'h0, resistorEnables}, 8'h06);
      end_sim();
   end
endmodule
